// ---- pps_pkg.sv ----
package pps_pkg;

   // ******************************
   // register offsets
   // ******************************
   localparam logic [7:0] OFS_BASIC_STATUS = 8'h02;
   localparam logic [7:0] OFS_IDENT_LOW    = 8'h04;
   localparam logic [7:0] OFS_IDENT_HIGH   = 8'h06;
   localparam logic [7:0] OFS_NEG_ADVERT   = 8'h08;
   localparam logic [7:0] OFS_ALIAS_CTRL   = 8'h12;
   localparam logic [7:0] OFS_ALIAS_STAT   = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS   = 8'h16;
   localparam logic [7:0] OFS_IRQ_MASK     = 8'h18;

   // ******************************
   // basic status field positions
   // ******************************
   localparam int POS_T4_ABLE    = 15;
   localparam int POS_100F_ABLE  = 14;
   localparam int POS_100H_ABLE  = 13;
   localparam int POS_10F_ABLE   = 12;
   localparam int POS_10H_ABLE   = 11;
   localparam int POS_NEG_DONE   = 5;
   localparam int POS_NEG_ABLE   = 3;
   localparam int POS_LINK_UP    = 2;
   localparam int POS_EXT_ABLE   = 0;

   // ******************************
   // advertisement field positions
   // ******************************
   localparam int POS_ADV_PAUSE  = 10;
   localparam int POS_ADV_100F   = 8;
   localparam int POS_ADV_10H    = 5;
   localparam int POS_SEL_LSB    = 0;
   localparam int POS_SEL_MSB    = 4;
   localparam logic [4:0] SELECTOR_VAL = 5'h01;

   // ******************************
   // alias bank field positions
   // ******************************
   localparam int POS_ALIAS_DONE = 6;
   localparam int POS_ALIAS_LINK = 5;

   // ******************************
   // interrupt event bits
   // ******************************
   localparam int IRQ_BITS       = 2;
   localparam int IRQ_LINK_CHG   = 0;
   localparam int IRQ_NEG_DONE   = 1;

   // ******************************
   // reset values
   // ******************************
   localparam logic [4:0]          RST_ADV      = 5'h1f;
   localparam logic [IRQ_BITS-1:0] RST_IRQ_MASK = 2'h0;

   // ******************************
   // block state
   // ******************************
   typedef struct packed {
      logic [15:0]         rdata;
      logic [4:0]          adv;      // pause,100f,100h,10f,10h
      logic                link;
      logic                done;
      logic                ext;
      logic [IRQ_BITS-1:0] irq_sts;
      logic [IRQ_BITS-1:0] irq_mask;
      logic                irq;
   } pps_state_t;

endpackage

// ---- pps_regs.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - The basic status word is read-only and its bit 15 always reads 0 (no T4).
// - Status bits 14 and 13 read 1 for 100 Mb/s full and half duplex ability.
// - Status bits 12 and 11 read 1 for 10 Mb/s full and half duplex ability.
// - Status bit 5 shows negotiation done, resets 0, and equals bit 6 of the alias status.
// - Status bit 3 reads constant 1 since the port can negotiate.
// - Status bit 2 shows the live link, resets 0, and equals bit 5 of the alias status.
// - Status bit 0 shows extended register ability and resets 0.
// - The identifier is two read-only words, low half at 0x04 and high half at 0x06.
// - Advertisement bit 10 is writable pause ability, resets 1, aliased to control bit 4.
// - Advertisement bits 8 and 7 are writable 100 Mb/s abilities, aliased to bits 3 and 2.
// - Advertisement bits 6 and 5 are writable 10 Mb/s abilities, aliased to bits 1 and 0.
// - Advertisement bits 4 to 0 are a read-only selector fixed at 0x01.
module pps_regs #(
   parameter logic [15:0] IDENT_LOW  = 16'h5a5a,   // arbitrary value
   parameter logic [15:0] IDENT_HIGH = 16'ha5a5    // arbitrary value
) (
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   // transceiver status
   input  wire logic        i_link_up,
   input  wire logic        i_neg_done,
   input  wire logic        i_ext_able,
   // advertisement to transceiver
   output logic      [4:0]  o_adv,
   // interrupt
   output logic             o_irq
);

   pps_pkg::pps_state_t st_r;
   pps_pkg::pps_state_t st_nxt;

   // ******************************
   // read words
   // ******************************
   function automatic logic [15:0] basic_word(input pps_pkg::pps_state_t s);
      logic [15:0] w;
      w = 16'h0000;
      w[pps_pkg::POS_T4_ABLE] = 1'b0;
      w[pps_pkg::POS_100F_ABLE] = 1'b1;
      w[pps_pkg::POS_100H_ABLE] = 1'b1;
      w[pps_pkg::POS_10F_ABLE] = 1'b1;
      w[pps_pkg::POS_10H_ABLE] = 1'b1;
      w[pps_pkg::POS_NEG_DONE] = s.done;
      w[pps_pkg::POS_NEG_ABLE] = 1'b1;
      w[pps_pkg::POS_LINK_UP] = s.link;
      w[pps_pkg::POS_EXT_ABLE] = s.ext;
      return w;
   endfunction

   function automatic logic [15:0] advert_word(input pps_pkg::pps_state_t s);
      logic [15:0] w;
      w = 16'h0000;
      w[pps_pkg::POS_ADV_PAUSE] = s.adv[4];
      w[pps_pkg::POS_ADV_100F -: 4] = s.adv[3:0];
      w[pps_pkg::POS_SEL_MSB:pps_pkg::POS_SEL_LSB] = pps_pkg::SELECTOR_VAL;
      return w;
   endfunction

   // ******************************
   // next state
   // ******************************
   always_comb begin
      logic [pps_pkg::IRQ_BITS-1:0] ev;
      logic                         rd_sts;
      ev = '0;
      rd_sts = 1'b0;
      st_nxt = st_r;
      st_nxt.rdata = 16'h0000;
      st_nxt.link = i_link_up;
      st_nxt.done = i_neg_done;
      st_nxt.ext = i_ext_able;
      ev[pps_pkg::IRQ_LINK_CHG] = i_link_up ^ st_r.link;
      ev[pps_pkg::IRQ_NEG_DONE] = i_neg_done & ~st_r.done;
      if (i_rd) begin
         case (i_addr)
            pps_pkg::OFS_BASIC_STATUS: begin
               st_nxt.rdata = basic_word(st_r);
            end
            pps_pkg::OFS_IDENT_LOW: begin
               st_nxt.rdata = IDENT_LOW;
            end
            pps_pkg::OFS_IDENT_HIGH: begin
               st_nxt.rdata = IDENT_HIGH;
            end
            pps_pkg::OFS_NEG_ADVERT: begin
               st_nxt.rdata = advert_word(st_r);
            end
            pps_pkg::OFS_ALIAS_CTRL: begin
               st_nxt.rdata = {11'h000, st_r.adv};
            end
            pps_pkg::OFS_ALIAS_STAT: begin
               st_nxt.rdata[pps_pkg::POS_ALIAS_DONE] = st_r.done;
               st_nxt.rdata[pps_pkg::POS_ALIAS_LINK] = st_r.link;
            end
            pps_pkg::OFS_IRQ_STATUS: begin
               st_nxt.rdata = {14'h0000, st_r.irq_sts};
               rd_sts = 1'b1;
            end
            pps_pkg::OFS_IRQ_MASK: begin
               st_nxt.rdata = {14'h0000, st_r.irq_mask};
            end
            default: begin
               st_nxt.rdata = 16'h0000;
            end
         endcase
      end
      // a fresh event beats the clear-on-read
      st_nxt.irq_sts = (rd_sts ? '0 : st_r.irq_sts) | ev;
      if (i_wr) begin
         case (i_addr)
            pps_pkg::OFS_NEG_ADVERT: begin
               st_nxt.adv = {i_wdata[pps_pkg::POS_ADV_PAUSE],
                             i_wdata[pps_pkg::POS_ADV_100F -: 4]};
            end
            pps_pkg::OFS_ALIAS_CTRL: begin
               st_nxt.adv = i_wdata[4:0];
            end
            pps_pkg::OFS_IRQ_MASK: begin
               st_nxt.irq_mask = i_wdata[pps_pkg::IRQ_BITS-1:0];
            end
            default: begin
               st_nxt.adv = st_r.adv;
            end
         endcase
      end
      st_nxt.irq = |(st_nxt.irq_sts & st_nxt.irq_mask);
   end

   // ******************************
   // state register
   // ******************************
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st_r.rdata <= 16'h0000;
         st_r.adv <= pps_pkg::RST_ADV;
         st_r.link <= 1'b0;
         st_r.done <= 1'b0;
         st_r.ext <= 1'b0;
         st_r.irq_sts <= '0;
         st_r.irq_mask <= pps_pkg::RST_IRQ_MASK;
         st_r.irq <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rdata = st_r.rdata;
   assign o_adv = st_r.adv;
   assign o_irq = st_r.irq;

   // ******************************
   // assertions
   // ******************************
   sequence s_rd(logic [7:0] a);
      i_rd && (i_addr == a);
   endsequence

   sequence s_wr(logic [7:0] a);
      i_wr && (i_addr == a);
   endsequence

   property p_t4_zero;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_rd(pps_pkg::OFS_BASIC_STATUS) |=> (o_rdata[15] == 1'b0);
   endproperty
   a_t4_zero: assert property (p_t4_zero) else $error("t4 bit not zero");

   property p_100_able;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_rd(pps_pkg::OFS_BASIC_STATUS) |=> (o_rdata[14:13] == 2'h3);
   endproperty
   a_100_able: assert property (p_100_able) else $error("100 ability bits wrong");

   property p_10_able;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_rd(pps_pkg::OFS_BASIC_STATUS) |=> (o_rdata[12:11] == 2'h3);
   endproperty
   a_10_able: assert property (p_10_able) else $error("10 ability bits wrong");

   // both words come from the same flop only if the input held across the first read
   property p_neg_done;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_rd(pps_pkg::OFS_BASIC_STATUS) ##0 $stable(i_neg_done) ##1 s_rd(pps_pkg::OFS_ALIAS_STAT)
         |=> (o_rdata[6] == $past(o_rdata[5], 1)) && (o_rdata[6] == $past(i_neg_done, 2));
   endproperty
   a_neg_done: assert property (p_neg_done) else $error("negotiation done mismatch");

   property p_neg_able;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_rd(pps_pkg::OFS_BASIC_STATUS) |=> o_rdata[3];
   endproperty
   a_neg_able: assert property (p_neg_able) else $error("negotiation able bit low");

   property p_link;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_rd(pps_pkg::OFS_BASIC_STATUS) |=> (o_rdata[2] == $past(i_link_up, 2));
   endproperty
   a_link: assert property (p_link) else $error("link bit stale");

   property p_ext;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_rd(pps_pkg::OFS_BASIC_STATUS) |=> (o_rdata[0] == $past(i_ext_able, 2));
   endproperty
   a_ext: assert property (p_ext) else $error("extended bit stale");

   property p_ident;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_rd(pps_pkg::OFS_IDENT_LOW) ##1 s_rd(pps_pkg::OFS_IDENT_HIGH)
         |=> (o_rdata == IDENT_HIGH) && ($past(o_rdata, 1) == IDENT_LOW);
   endproperty
   a_ident: assert property (p_ident) else $error("identifier word wrong");

   property p_adv_write;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_wr(pps_pkg::OFS_NEG_ADVERT) ##1 s_rd(pps_pkg::OFS_ALIAS_CTRL)
         |=> (o_rdata[4:0] == {$past(i_wdata[10], 2), $past(i_wdata[8:5], 2)});
   endproperty
   a_adv_write: assert property (p_adv_write) else $error("pause or speed alias lost");

   property p_alias_write;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_wr(pps_pkg::OFS_ALIAS_CTRL) ##1 s_rd(pps_pkg::OFS_NEG_ADVERT)
         |=> (o_rdata[10] == $past(i_wdata[4], 2)) && (o_rdata[8:5] == $past(i_wdata[3:0], 2));
   endproperty
   a_alias_write: assert property (p_alias_write) else $error("alias write not seen");

   property p_adv_reset;
      @(posedge i_clk_sys)
      $fell(i_rst) |-> (o_adv == pps_pkg::RST_ADV);
   endproperty
   a_adv_reset: assert property (p_adv_reset) else $error("advert reset value wrong");

   property p_adv_out;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_wr(pps_pkg::OFS_NEG_ADVERT) |=> (o_adv[1:0] == $past(i_wdata[6:5]));
   endproperty
   a_adv_out: assert property (p_adv_out) else $error("10 mb ability not stored");

   property p_selector;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_rd(pps_pkg::OFS_NEG_ADVERT) |=> (o_rdata[4:0] == 5'h01);
   endproperty
   a_selector: assert property (p_selector) else $error("selector not 0x01");

   property p_reserved;
      @(posedge i_clk_sys) disable iff (i_rst)
      (s_rd(pps_pkg::OFS_BASIC_STATUS) |=> (o_rdata[10:6] == 5'h00) && !o_rdata[4]
         && !o_rdata[1])
      and (s_rd(pps_pkg::OFS_NEG_ADVERT) |=> (o_rdata[15:11] == 5'h00) && !o_rdata[9]);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_irq_sticky;
      @(posedge i_clk_sys) disable iff (i_rst)
      $rose(i_neg_done) ##1 s_rd(pps_pkg::OFS_IRQ_STATUS) |=> o_rdata[1];
   endproperty
   a_irq_sticky: assert property (p_irq_sticky) else $error("done event not latched");

   // read data stand one cycle only, so a stale word never leaks into a later access
   property p_rdata_idle;
      @(posedge i_clk_sys) disable iff (i_rst)
      !i_rd |=> (o_rdata == 16'h0000);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

   property p_ro_ignore;
      @(posedge i_clk_sys) disable iff (i_rst)
      i_wr && (i_addr != pps_pkg::OFS_NEG_ADVERT) && (i_addr != pps_pkg::OFS_ALIAS_CTRL)
         |=> $stable(o_adv);
   endproperty
   a_ro_ignore: assert property (p_ro_ignore) else $error("advert moved by write");

   // an event landing on the clearing read must not be lost
   property p_set_wins;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_rd(pps_pkg::OFS_IRQ_STATUS) ##0 $changed(i_link_up)
         |=> st_r.irq_sts[pps_pkg::IRQ_LINK_CHG];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("link event lost on clear");

   property p_irq_cleared;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_rd(pps_pkg::OFS_IRQ_STATUS) ##0 ($stable(i_link_up) && !$rose(i_neg_done))
         |=> !o_irq;
   endproperty
   a_irq_cleared: assert property (p_irq_cleared) else $error("interrupt kept after clear");

endmodule

// ---- pps_tb.sv ----
`timescale 1ns/1ns
module testbench;
   // ************
   // signals
   // ************
   logic        clk;
   logic        rst;
   logic [7:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic        link;
   logic        done;
   logic        ext;
   logic [4:0]  adv;
   logic        irq;
   int          err_count;
   int          n_tests;
   logic [31:0] seed;
   logic [15:0] d;
   logic [15:0] d2;
   logic [31:0] r;
   localparam logic [15:0] STS_FIXED = 16'h7808;

   pps_regs u_dut (
      .i_clk_sys  (clk),
      .i_rst      (rst),
      .i_addr     (addr),
      .i_wdata    (wdata),
      .i_wr       (wr),
      .i_rd       (rd),
      .o_rdata    (rdata),
      .i_link_up  (link),
      .i_neg_done (done),
      .i_ext_able (ext),
      .o_adv      (adv),
      .o_irq      (irq)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ************
   // helpers
   // ************
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [15:0] sts_word(logic l, logic dn, logic e);
      return STS_FIXED | {10'h0, dn, 1'b0, 1'b0, l, 1'b0, e};
   endfunction

   // advertisement word from the five ability bits
   function automatic logic [15:0] adv_word(logic [4:0] a);
      return {5'h0, a[4], 1'b0, a[3:0], 5'h01};
   endfunction

   task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
      n_tests++;
      if (exp !== got) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr_reg(logic [7:0] a, logic [15:0] v);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe
   task automatic rd_reg(logic [7:0] a, output logic [15:0] v);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic rd_chk(string name, logic [7:0] a, logic [15:0] exp);
      logic [15:0] v;
      rd_reg(a, v);
      chk(name, exp, v);
   endtask

   // back-to-back reads, the strobe held high across both
   task automatic rd_rd(logic [7:0] a1, logic [7:0] a2, output logic [15:0] v1,
                        output logic [15:0] v2);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a1;
      @(posedge clk);
      addr <= a2;
      #1 v1 = rdata;
      @(posedge clk);
      rd   <= 1'b0;
      #1 v2 = rdata;
   endtask

   // write, then read in the very next cycle
   task automatic wr_rd(logic [7:0] aw, logic [15:0] w, logic [7:0] ar,
                        output logic [15:0] v);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= aw;
      wdata <= w;
      @(posedge clk);
      wr    <= 1'b0;
      rd    <= 1'b1;
      addr  <= ar;
      @(posedge clk);
      rd    <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (6000) @(posedge clk);
      err_count++;
      tally_and_finish();
   end

   // ************
   // main sequence
   // ************
   initial begin
      err_count = 0;
      n_tests = 0;
      seed = 32'h00000041;
      rst = 1'b1;
      addr = 8'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      link = 1'b0;
      done = 1'b0;
      ext = 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd_reg(pps_pkg::OFS_BASIC_STATUS, d);
      chk("status at reset", STS_FIXED, d);
      rd_chk("advert at reset", pps_pkg::OFS_NEG_ADVERT, 16'h05e1);
      chk("adv out at reset", 16'h001f, {11'h0, adv});
      rd_rd(pps_pkg::OFS_IDENT_LOW, pps_pkg::OFS_IDENT_HIGH, d, d2);
      chk("ident low", 16'h5a5a, d);
      chk("ident high", 16'ha5a5, d2);
      rd_chk("unmapped", 8'h0a, 16'h0000);
      wr_reg(pps_pkg::OFS_BASIC_STATUS, 16'hffff);
      wr_reg(pps_pkg::OFS_IDENT_LOW, 16'h0000);
      wr_reg(pps_pkg::OFS_IDENT_HIGH, 16'h0000);
      rd_chk("status after write", pps_pkg::OFS_BASIC_STATUS, STS_FIXED);
      rd_chk("ident low after write", pps_pkg::OFS_IDENT_LOW, 16'h5a5a);
      rd_chk("ident high after write", pps_pkg::OFS_IDENT_HIGH, 16'ha5a5);
      $display("test reset and read-only done");

      // random advert writes through both addresses
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         wr_reg(pps_pkg::OFS_NEG_ADVERT, r[15:0]);
         rd_reg(pps_pkg::OFS_NEG_ADVERT, d);
         chk("advert", adv_word({r[10], r[8:5]}), d);
         chk("adv out", {11'h0, r[10], r[8:5]}, {11'h0, adv});
         rd_chk("alias ctrl", pps_pkg::OFS_ALIAS_CTRL, {11'h0, r[10], r[8:5]});
         wr_rd(pps_pkg::OFS_ALIAS_CTRL, r[31:16], pps_pkg::OFS_NEG_ADVERT, d);
         chk("advert via alias", adv_word(r[20:16]), d);
      end
      wr_rd(pps_pkg::OFS_NEG_ADVERT, 16'hffff, pps_pkg::OFS_ALIAS_CTRL, d);
      chk("alias after all ones", 16'h001f, d);
      rd_chk("advert all ones", pps_pkg::OFS_NEG_ADVERT, 16'h05e1);
      wr_reg(pps_pkg::OFS_NEG_ADVERT, 16'h0000);
      rd_chk("advert all zeros", pps_pkg::OFS_NEG_ADVERT, 16'h0001);
      chk("adv out all zeros", 16'h0000, {11'h0, adv});
      // a second reset must bring back the abilities just cleared
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk("adv out after reset", 16'h001f, {11'h0, adv});
      rd_chk("advert after reset", pps_pkg::OFS_NEG_ADVERT, 16'h05e1);
      $display("test advertisement done");

      // random status inputs, seen in both words read back to back
      for (int i = 0; i < 10; i++) begin
         r = rnd();
         @(posedge clk);
         link <= r[0];
         done <= r[1];
         ext  <= r[2];
         repeat (2) @(posedge clk);
         rd_rd(pps_pkg::OFS_BASIC_STATUS, pps_pkg::OFS_ALIAS_STAT, d, d2);
         chk("status", sts_word(r[0], r[1], r[2]), d);
         chk("alias status", {9'h0, r[1], r[0], 5'h0}, d2);
      end
      $display("test status inputs done");

      // interrupt: unmasked, cleared by read, then masked
      wr_reg(pps_pkg::OFS_IRQ_MASK, 16'h0003);
      rd_chk("irq mask", pps_pkg::OFS_IRQ_MASK, 16'h0003);
      rd_reg(pps_pkg::OFS_IRQ_STATUS, d);
      repeat (3) @(posedge clk);
      chk("irq idle", 16'h0000, {15'h0, irq});
      @(posedge clk);
      link <= ~link;
      repeat (3) @(posedge clk);
      chk("irq raised", 16'h0001, {15'h0, irq});
      rd_chk("irq status", pps_pkg::OFS_IRQ_STATUS, 16'h0001);
      repeat (2) @(posedge clk);
      chk("irq cleared", 16'h0000, {15'h0, irq});
      wr_reg(pps_pkg::OFS_IRQ_MASK, 16'h0000);
      @(posedge clk);
      link <= ~link;
      repeat (3) @(posedge clk);
      chk("irq masked", 16'h0000, {15'h0, irq});
      rd_chk("irq status masked", pps_pkg::OFS_IRQ_STATUS, 16'h0001);
      rd_chk("irq status clear", pps_pkg::OFS_IRQ_STATUS, 16'h0000);
      // a link change in the very cycle of the clearing read must survive it
      @(posedge clk);
      link <= ~link;
      rd   <= 1'b1;
      addr <= pps_pkg::OFS_IRQ_STATUS;
      @(posedge clk);
      rd   <= 1'b0;
      rd_chk("irq event beats clear", pps_pkg::OFS_IRQ_STATUS, 16'h0001);
      // negotiation done rising, read one cycle later
      @(posedge clk);
      done <= 1'b0;
      rd_reg(pps_pkg::OFS_IRQ_STATUS, d);
      @(posedge clk);
      done <= 1'b1;
      rd_chk("irq done event", pps_pkg::OFS_IRQ_STATUS, 16'h0002);
      $display("test interrupt done");
      tally_and_finish();
   end
endmodule
